// ### dv/spi_fram_memory_access_test.sv
// Self-checking bench for the serial memory engine
`timescale 1ns/1ns
`default_nettype none
module spi_fram_memory_access_test;
   logic                      clk_sys = 1'b0;
   logic                      rst = 1'b1;
   logic                      bp_lo = 1'b0;
   logic                      bp_hi = 1'b0;
   logic                      pat = 1'b0;
   logic                      stb = 1'b0;
   logic                      so_data, so_oe, wl, slp;
   logic [7:0]                rx, got, d [4];
   logic [7:0]                exp_q [$];
   int                        mismatches = 0;
   int                        checked = 0;
   int                        seed = 90889;
   spifr_pkg::spifr_pins_type pins;
   wire logic                 so_line = so_oe ? so_data : pat;
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) pat <= ~pat;
   spifr_master m (.clk_sys(clk_sys), .so(so_line), .pins(pins));
   spifr_top u_dut (.clk_sys(clk_sys), .rst(rst), .cs_n(pins.cs_n), .sck(pins.sck),
      .si(pins.si), .hold_n(pins.hold_n), .block_protect_lo(bp_lo),
      .block_protect_hi(bp_hi), .so_data(so_data), .so_oe(so_oe),
      .write_latch_flag(wl), .asleep_flag(slp));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic ad);
      m.sel(1'b1);
      m.xfer(op, 1'b0, rx);
      if (ad)
         m.xfer(a[15:8], 1'b0, rx);
      if (ad)
         m.xfer(a[7:0], 1'b0, rx);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] x, input logic [7:0] y);
      cmd(8'h06, 16'h0000, 1'b0);
      m.sel(1'b0);
      check({7'h00, wl}, 8'h01);
      cmd(8'h02, a, 1'b1);
      m.xfer(x, 1'b0, rx);
      m.xfer(y, 1'b0, rx);
      m.sel(1'b0);
   endtask
   task automatic rd(input logic [7:0] want, input logic hld);
      exp_q.push_back(want);
      m.xfer(8'($random(seed)), hld, got);
      stb = ~stb;
   endtask
   always @(stb)
      check(got, exp_q.pop_front());
   initial begin
      for (int i = 0; i < 4; i++)
         d[i] = 8'($random(seed));
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      wr(16'hFFFE, d[0], d[1]);
      wr(16'hFFFF, d[1], d[2]);
      check({7'h00, wl}, 8'h00);
      cmd(8'h02, 16'h7FFE, 1'b1);
      m.xfer(~d[0], 1'b0, rx);
      m.sel(1'b0);
      wr(16'h5FFF, d[3], d[0]);
      bp_lo = ~bp_lo;
      wr(16'h5FFF, d[1], d[2]);
      bp_hi = ~bp_hi;
      wr(16'h7FFE, d[3], d[3]);
      cmd(8'h03, 16'h7FFE, 1'b1);
      rd(d[0], 1'b0);
      rd(d[1], 1'b1);
      rd(d[2], 1'b0);
      m.sel(1'b0);
      check({7'h00, so_oe}, 8'h00);
      cmd(8'h0B, 16'h5FFF, 1'b1);
      m.xfer(8'h00, 1'b0, rx);
      rd(d[1], 1'b0);
      rd(d[0], 1'b0);
      m.sel(1'b0);
      cmd(8'h06, 16'h0000, 1'b0);
      m.sel(1'b0);
      cmd(8'h05, 16'h0000, 1'b0);
      rd(8'h0E, 1'b0);
      m.sel(1'b0);
      cmd(8'h04, 16'h0000, 1'b0);
      m.sel(1'b0);
      check({7'h00, wl}, 8'h00);
      cmd(8'hB9, 16'h0000, 1'b0);
      m.sel(1'b0);
      check({6'h00, slp, so_oe}, 8'h02);
      m.sel(1'b1);
      m.xfer(8'h03, 1'b0, rx);
      m.sel(1'b0);
      check({7'h00, slp}, 8'h00);
      cmd(8'h9F, 16'h0000, 1'b0);
      for (int i = 0; i < 9; i++)
         rd(i < 6 ? 8'hA5 : i == 6 ? 8'h3C : i == 7 ? 8'h43 : 8'h50, 1'b0);
      m.sel(1'b0);
      cmd(8'h5A, 16'h0000, 1'b0);
      m.xfer(8'hFF, 1'b0, rx);
      check({7'h00, so_oe}, 8'h00);
      m.sel(1'b0);
      tally_and_finish();
   end
   initial begin
      #2000000;
      mismatches++;
      tally_and_finish();
   end
endmodule // spi_fram_memory_access_test
`default_nettype wire

// ### dv/spifr_master.sv
// Serial bus master model driving the memory pins
`timescale 1ns/1ns
`default_nettype none
module spifr_master (
   input  wire logic                     clk_sys,
   input  wire logic                     so,
   output var spifr_pkg::spifr_pins_type pins
);
   initial pins = 4'b1001;
   task automatic ph();
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic sel(input logic on);
      ph();
      pins.cs_n = ~on;
      ph();
      ph();
   endtask
   task automatic xfer(input logic [7:0] tx, input logic hld, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         pins.si = tx[i];
         ph();
         pins.sck = ~pins.sck;
         rx[i] = so;
         ph();
         pins.sck = ~pins.sck;
         if (hld && i == 4) begin
            ph();
            pins.hold_n = ~pins.hold_n;
            ph();
            pins.sck = ~pins.sck;
            ph();
            pins.sck = ~pins.sck;
            ph();
            pins.hold_n = ~pins.hold_n;
            ph();
         end
      end
   endtask
endmodule // spifr_master
`default_nettype wire

// ### src/spifr_mem.sv
// Byte-wide storage array with one write and one registered read port
`timescale 1ns/1ns
`default_nettype none

module spifr_mem #(
   parameter int AW = 15,
   parameter int DW = 8
) (
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   // ----------------------------------------------------------------
   // Array
   // ----------------------------------------------------------------
   logic [DW-1:0] mem_array [0:(1<<AW)-1];

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem_array[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= mem_array[raddr];
      end
   end

endmodule // spifr_mem

`default_nettype wire

// ### src/spifr_pkg.sv
// Shared constants, types and helpers for the serial ferroelectric memory engine
package spifr_pkg;

   // ----------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 15;
   localparam int          DATA_W       = 8;
   localparam logic [14:0] TOP_ADDR     = 15'h7FFF;
   localparam logic [14:0] QUARTER_BASE = 15'h6000;
   localparam logic [14:0] HALF_BASE    = 15'h4000;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_SET_LATCH   = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_READ        = 8'h03;
   localparam logic [7:0] OP_FAST_READ   = 8'h0B;
   localparam logic [7:0] OP_WRITE       = 8'h02;
   localparam logic [7:0] OP_SLEEP       = 8'hB9;
   localparam logic [7:0] OP_READ_ID     = 8'h9F;

   // ----------------------------------------------------------------
   // Identification readout layout
   // ----------------------------------------------------------------
   localparam int         ID_BYTES    = 9;
   localparam int         CONT_BYTES  = 6;
   localparam logic [3:0] ID_LAST_IDX = 4'h9;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 50;
   localparam int WAKE_RECOVERY_NS = 400;
   localparam int WAKE_CYC         = (WAKE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
   } spifr_pins_type;

   typedef enum logic [1:0] {XFER_READ, XFER_FAST, XFER_WRITE} spifr_xfer_type;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_WRITE, ST_READ,
      ST_STATUS, ST_ID, ST_IGNORE, ST_SLEEP, ST_WAKE
   } spifr_state_type;

   // Protected range per block-protect code
   function automatic logic protected_fn(input logic [14:0] addr,
                                         input logic        bp_hi,
                                         input logic        bp_lo);
      logic prot;
      prot = 1'b0;
      case ({bp_hi, bp_lo})
         2'b00:   prot = 1'b0;
         2'b01:   prot = (addr >= QUARTER_BASE);
         2'b10:   prot = (addr >= HALF_BASE);
         default: prot = 1'b1;
      endcase
      return prot;
   endfunction

endpackage

// ### src/spifr_sync.sv
// Two-stage pin synchroniser with edge detection per bit
`timescale 1ns/1ns
`default_nettype none

module spifr_sync #(
   parameter int W = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   // ----------------------------------------------------------------
   // Per-bit stages
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               s1_reg <= 1'b1;
               s2_reg <= 1'b1;
               s3_reg <= 1'b1;
            end else begin
               s1_reg <= din[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         assign level[i] = s2_reg;
         assign rise[i]  = s2_reg & ~s3_reg;
         assign fall[i]  = ~s2_reg & s3_reg;
      end
   endgenerate

endmodule // spifr_sync

`default_nettype wire

// ### src/spifr_top.sv
// Serial command engine of the ferroelectric memory, sampled on the system clock
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE_01] Master sends latch-set in its own frame
// [RULE_02] Two address bytes, top bit dropped
// [RULE_03] Address advances per byte, wraps to zero
// [RULE_04] Write data MSB first, deselect ends
// [RULE_05] Protected address stops increment, drops bytes
// [RULE_06] Each byte committed after eighth bit
// [RULE_07] Read drives data, input ignored
// [RULE_08] Read MSB first, deselect floats output
// [RULE_09] Fast read adds one dummy byte
// [RULE_10] Fast read streams, ignores input, floats
// [RULE_11] Hold pauses and resumes with clock low
// [RULE_12] Master moves hold only with clock low
// [RULE_13] Sleep after opcode plus deselect edge
// [RULE_14] Asleep: ignore clock, input; float output
// [RULE_15] Select fall wakes within recovery time
// [RULE_16] Master may wake with throwaway read
// [RULE_17] Identity: nine bytes, maker then product
// [RULE_18] Six continuation bytes then maker byte
// [RULE_19] Product field: family, density, sub, rev
// [RULE_20] Latch set by command, cleared after write
// [RULE_21] Protect codes: none, quarter, half, all
// [RULE_22] Opcode is first byte after select
// [RULE_23] Unknown opcode ignored until next select
module spifr_top #(
   parameter logic [7:0]  ID_CONT_CODE  = 8'hA5,   // Arbitrary value
   parameter logic [7:0]  ID_MAKER_CODE = 8'h3C,   // Arbitrary value
   parameter logic [2:0]  ID_FAMILY     = 3'h2,    // Arbitrary value
   parameter logic [4:0]  ID_DENSITY    = 5'h03,   // Arbitrary value
   parameter logic [1:0]  ID_SUB        = 2'h1,    // Arbitrary value
   parameter logic [2:0]  ID_REV        = 3'h2     // Arbitrary value
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic hold_n,
   input  wire logic block_protect_lo,
   input  wire logic block_protect_hi,
   output logic      so_data,
   output logic      so_oe,
   output logic      write_latch_flag,
   output logic      asleep_flag
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int WAKE_W = $clog2(spifr_pkg::WAKE_CYC + 1);

   spifr_pkg::spifr_pins_type  pin_raw;
   spifr_pkg::spifr_pins_type  pin_lvl;
   spifr_pkg::spifr_pins_type  pin_rise;
   spifr_pkg::spifr_pins_type  pin_fall;
   spifr_pkg::spifr_state_type state_reg;
   spifr_pkg::spifr_xfer_type  xfer_reg;
   logic [2:0]                 bit_cnt_reg;
   logic [7:0]                 rx_reg;
   logic [7:0]                 rx_byte;
   logic                       addr_byte_reg;
   logic [3:0]                 id_idx_reg;
   logic                       sleep_arm_reg;
   logic [14:0]                addr_reg;
   logic                       wel_reg;
   logic                       clr_arm_reg;
   logic                       held_reg;
   logic [WAKE_W-1:0]          wake_cnt_reg;
   logic                       so_reg;
   logic                       so_oe_reg;
   logic                       asleep_reg;
   logic                       mem_we_reg;
   logic [14:0]                mem_waddr_reg;
   logic [7:0]                 mem_wdata_reg;
   logic [7:0]                 mem_rdata;
   logic [7:0]                 src_byte;
   logic [15:0]                product_id;
   logic                       in_frame;
   logic                       in_sleep;
   logic                       out_state;
   logic                       rise_act;
   logic                       fall_act;
   logic                       byte_done;
   logic                       cmd_done;
   logic                       cs_rise_act;
   logic                       wr_ok;

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   assign pin_raw = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n};

   spifr_sync #(.W(4)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (pin_raw),
      .level   (pin_lvl),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   // ----------------------------------------------------------------
   // Qualifiers
   // ----------------------------------------------------------------
   assign in_sleep    = (state_reg == spifr_pkg::ST_SLEEP) || (state_reg == spifr_pkg::ST_WAKE);
   assign in_frame    = (state_reg != spifr_pkg::ST_IDLE) && !in_sleep;
   assign out_state   = (state_reg == spifr_pkg::ST_READ) || (state_reg == spifr_pkg::ST_STATUS)
                        || (state_reg == spifr_pkg::ST_ID);
   assign rise_act    = pin_rise.sck && !pin_lvl.cs_n && !held_reg && in_frame;
   assign fall_act    = pin_fall.sck && !pin_lvl.cs_n && !held_reg && out_state;
   assign byte_done   = rise_act && (bit_cnt_reg == 3'd7);
   assign cmd_done    = byte_done && (state_reg == spifr_pkg::ST_CMD);
   assign cs_rise_act = pin_rise.cs_n && !held_reg;
   assign rx_byte     = {rx_reg[6:0], pin_lvl.si};
   assign wr_ok       = (state_reg == spifr_pkg::ST_WRITE) && wel_reg
                        && !spifr_pkg::protected_fn(addr_reg, block_protect_hi, block_protect_lo); // RULE_05 RULE_21
   assign product_id  = {ID_FAMILY, ID_DENSITY, ID_SUB, ID_REV, 3'h0}; // RULE_19

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg     <= spifr_pkg::ST_IDLE;
         xfer_reg      <= spifr_pkg::XFER_READ;
         bit_cnt_reg   <= 3'd0;
         rx_reg        <= 8'h00;
         addr_byte_reg <= 1'b0;
         id_idx_reg    <= 4'h0;
         sleep_arm_reg <= 1'b0;
      end else if (cs_rise_act && !in_sleep) begin
         state_reg     <= sleep_arm_reg ? spifr_pkg::ST_SLEEP : spifr_pkg::ST_IDLE; // RULE_13 RULE_04
         sleep_arm_reg <= 1'b0; // RULE_13
      end else if (pin_fall.cs_n && !held_reg && (state_reg == spifr_pkg::ST_IDLE)) begin
         state_reg     <= spifr_pkg::ST_CMD; // RULE_22
         bit_cnt_reg   <= 3'd0;
         addr_byte_reg <= 1'b0;
         id_idx_reg    <= 4'h0;
         sleep_arm_reg <= 1'b0;
      end else if (pin_fall.cs_n && (state_reg == spifr_pkg::ST_SLEEP)) begin
         state_reg <= spifr_pkg::ST_WAKE; // RULE_15
      end else if ((state_reg == spifr_pkg::ST_WAKE) && (wake_cnt_reg == '0)) begin
         state_reg <= spifr_pkg::ST_IDLE; // RULE_15
      end else if (rise_act) begin
         rx_reg      <= rx_byte; // RULE_04
         bit_cnt_reg <= bit_cnt_reg + 3'd1;
         if (bit_cnt_reg == 3'd7) begin
            case (state_reg)
               spifr_pkg::ST_CMD: begin
                  case (rx_byte)
                     spifr_pkg::OP_READ: begin
                        xfer_reg  <= spifr_pkg::XFER_READ;
                        state_reg <= spifr_pkg::ST_ADDR;
                     end
                     spifr_pkg::OP_FAST_READ: begin
                        xfer_reg  <= spifr_pkg::XFER_FAST;
                        state_reg <= spifr_pkg::ST_ADDR;
                     end
                     spifr_pkg::OP_WRITE: begin
                        xfer_reg  <= spifr_pkg::XFER_WRITE;
                        state_reg <= spifr_pkg::ST_ADDR;
                     end
                     spifr_pkg::OP_READ_STATUS: state_reg <= spifr_pkg::ST_STATUS;
                     spifr_pkg::OP_READ_ID:     state_reg <= spifr_pkg::ST_ID;
                     spifr_pkg::OP_SLEEP: begin
                        sleep_arm_reg <= 1'b1; // RULE_13
                        state_reg     <= spifr_pkg::ST_IGNORE;
                     end
                     default: state_reg <= spifr_pkg::ST_IGNORE; // RULE_23
                  endcase
               end
               spifr_pkg::ST_ADDR: begin
                  addr_byte_reg <= 1'b1; // RULE_02
                  if (addr_byte_reg) begin
                     case (xfer_reg)
                        spifr_pkg::XFER_WRITE: state_reg <= spifr_pkg::ST_WRITE;
                        spifr_pkg::XFER_FAST:  state_reg <= spifr_pkg::ST_DUMMY; // RULE_09
                        default:               state_reg <= spifr_pkg::ST_READ; // RULE_07
                     endcase
                  end
               end
               spifr_pkg::ST_DUMMY: state_reg <= spifr_pkg::ST_READ; // RULE_09
               spifr_pkg::ST_ID: begin
                  if (id_idx_reg != spifr_pkg::ID_LAST_IDX) begin
                     id_idx_reg <= id_idx_reg + 4'h1; // RULE_17
                  end
               end
               default: state_reg <= state_reg;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Address counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addr_reg <= 15'h0000;
      end else if (byte_done) begin
         if (state_reg == spifr_pkg::ST_ADDR) begin
            if (addr_byte_reg) begin
               addr_reg[7:0] <= rx_byte;
            end else begin
               addr_reg[14:8] <= rx_byte[6:0]; // RULE_02
            end
         end else if (wr_ok || (state_reg == spifr_pkg::ST_READ)) begin
            addr_reg <= addr_reg + 15'h0001; // RULE_03 RULE_05 RULE_10
         end
      end
   end

   // ----------------------------------------------------------------
   // Array write commit
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mem_we_reg    <= 1'b0;
         mem_waddr_reg <= 15'h0000;
         mem_wdata_reg <= 8'h00;
      end else begin
         mem_we_reg    <= byte_done && wr_ok; // RULE_06 RULE_05
         mem_waddr_reg <= addr_reg;
         mem_wdata_reg <= rx_byte;
      end
   end

   spifr_mem #(.AW(spifr_pkg::ADDR_W), .DW(spifr_pkg::DATA_W)) u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .we      (mem_we_reg),
      .waddr   (mem_waddr_reg),
      .wdata   (mem_wdata_reg),
      .raddr   (addr_reg),
      .rdata   (mem_rdata)
   );

   // ----------------------------------------------------------------
   // Write latch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wel_reg     <= 1'b0;
         clr_arm_reg <= 1'b0;
      end else begin
         if (cmd_done && (rx_byte == spifr_pkg::OP_SET_LATCH)) begin
            wel_reg <= 1'b1; // RULE_20
         end else if (cs_rise_act && clr_arm_reg && !in_sleep) begin
            wel_reg <= 1'b0; // RULE_20
         end
         if (cmd_done && ((rx_byte == spifr_pkg::OP_CLR_LATCH) || (rx_byte == spifr_pkg::OP_WRITE))) begin
            clr_arm_reg <= 1'b1;
         end else if (cs_rise_act) begin
            clr_arm_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Hold pause
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         held_reg <= 1'b0;
      end else if (!held_reg && !pin_lvl.hold_n && !pin_lvl.sck && !in_sleep) begin
         held_reg <= 1'b1; // RULE_11
      end else if (held_reg && pin_lvl.hold_n && !pin_lvl.sck) begin
         held_reg <= 1'b0; // RULE_11
      end
   end

   // ----------------------------------------------------------------
   // Wake recovery timer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wake_cnt_reg <= '0;
      end else if (state_reg == spifr_pkg::ST_SLEEP) begin
         wake_cnt_reg <= WAKE_W'(spifr_pkg::WAKE_CYC - 1); // RULE_15
      end else if ((state_reg == spifr_pkg::ST_WAKE) && (wake_cnt_reg != '0)) begin
         wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------
   always_comb begin
      src_byte = 8'h00;
      case (state_reg)
         spifr_pkg::ST_READ:   src_byte = mem_rdata;
         spifr_pkg::ST_STATUS: src_byte = {4'h0, block_protect_hi, block_protect_lo, wel_reg, 1'b0};
         spifr_pkg::ST_ID: begin
            if (id_idx_reg < 4'(spifr_pkg::CONT_BYTES)) begin
               src_byte = ID_CONT_CODE; // RULE_18
            end else if (id_idx_reg == 4'(spifr_pkg::CONT_BYTES)) begin
               src_byte = ID_MAKER_CODE; // RULE_18
            end else if (id_idx_reg == 4'(spifr_pkg::CONT_BYTES + 1)) begin
               src_byte = product_id[15:8]; // RULE_17
            end else if (id_idx_reg == 4'(spifr_pkg::ID_BYTES - 1)) begin
               src_byte = product_id[7:0];
            end
         end
         default: src_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         so_reg     <= 1'b0;
         so_oe_reg  <= 1'b0;
         asleep_reg <= 1'b0;
      end else begin
         so_oe_reg  <= out_state && !pin_lvl.cs_n && !held_reg && !pin_rise.cs_n; // RULE_08 RULE_14
         asleep_reg <= in_sleep;
         if (fall_act) begin
            so_reg <= src_byte[3'd7 - bit_cnt_reg]; // RULE_08
         end
      end
   end

   assign so_data          = so_reg;
   assign so_oe            = so_oe_reg;
   assign write_latch_flag = wel_reg;
   assign asleep_flag      = asleep_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_float_deselect: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
      pin_rise.cs_n |=> !so_oe_reg)
      else $error("Output driven after deselect");

   a_sleep_entry: assert property (@(posedge clk_sys) disable iff (rst) // RULE_13
      $rose(state_reg == spifr_pkg::ST_SLEEP) |-> $past(cs_rise_act) && $past(sleep_arm_reg))
      else $error("Sleep entered without opcode and deselect");

   a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RULE_14
      asleep_reg |-> !so_oe_reg && !mem_we_reg)
      else $error("Activity while asleep");

   a_wake_bound: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
      (state_reg == spifr_pkg::ST_SLEEP) && pin_fall.cs_n
      |=> (state_reg == spifr_pkg::ST_WAKE) ##[1:20] (state_reg == spifr_pkg::ST_IDLE))
      else $error("Wake recovery not finished in time");

   a_write_step: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
      byte_done && wr_ok |=> mem_we_reg && (addr_reg == $past(addr_reg) + 15'h0001))
      else $error("Write did not commit or advance");

   a_protect_drop: assert property (@(posedge clk_sys) disable iff (rst) // RULE_05
      mem_we_reg |-> !spifr_pkg::protected_fn(mem_waddr_reg, block_protect_hi, block_protect_lo))
      else $error("Write into protected block");

   a_latch_clear: assert property (@(posedge clk_sys) disable iff (rst) // RULE_20
      (state_reg == spifr_pkg::ST_WRITE) && cs_rise_act |=> !wel_reg)
      else $error("Write latch survived end of write");

   a_msb_first: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
      fall_act && (bit_cnt_reg == 3'd0) |=> so_reg == $past(src_byte[7]))
      else $error("First output bit is not the MSB");

   a_hold_freeze: assert property (@(posedge clk_sys) disable iff (rst) // RULE_11
      held_reg && (pin_rise.sck || pin_fall.sck) |=> $stable(bit_cnt_reg) && $stable(addr_reg))
      else $error("Progress while held");

   a_dummy_latency: assert property (@(posedge clk_sys) disable iff (rst) // RULE_09
      (state_reg == spifr_pkg::ST_DUMMY) && byte_done |=> (state_reg == spifr_pkg::ST_READ))
      else $error("Dummy byte not followed by data");

   a_ignore_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RULE_23
      (state_reg == spifr_pkg::ST_IGNORE) |-> !so_oe_reg && !mem_we_reg)
      else $error("Ignored opcode caused activity");

   a_read_no_write: assert property (@(posedge clk_sys) disable iff (rst) // RULE_10
      (state_reg == spifr_pkg::ST_READ) |-> !mem_we_reg)
      else $error("Input acted on during read data");

endmodule // spifr_top

`default_nettype wire
